// ### alt_defs.svh
// Register pointers, reset values and timing counts for the limit tracker
`ifndef ALT_DEFS_SVH
`define ALT_DEFS_SVH
`define ALT_PTR_RESULT 8'h00
`define ALT_PTR_STATUS 8'h01
`define ALT_PTR_LOWER 8'h03
`define ALT_PTR_UPPER 8'h04
`define ALT_PTR_HYST 8'h05
`define ALT_PTR_LOWEST 8'h06
`define ALT_PTR_HIGHEST 8'h07
`define ALT_UPPER_RST 12'hFFF
`define ALT_LOWER_RST 12'h000
`define ALT_HYST_RST 12'h000
`define ALT_LOWEST_RST 12'hFFF
`define ALT_HIGHEST_RST 12'h000
`define ALT_TARGET_ADDR 7'h54
`define ALT_STAT_UNDER 0
`define ALT_STAT_OVER 1
`define ALT_APB_TARGET 8'h00
`define ALT_APB_PTR 8'h04
`define ALT_APB_WDATA 8'h08
`define ALT_APB_CTRL 8'h0C
`define ALT_APB_STATUS 8'h10
`define ALT_APB_RDATA 8'h14
`define ALT_CTRL_GO 0
`define ALT_CTRL_READ 1
`define ALT_STS_BUSY 0
`define ALT_STS_NACK 1
`define ALT_SYS_PERIOD_NS 8
`define ALT_SCL_QTR_NS 625
`define ALT_SCL_QTR_CYC \
  ((`ALT_SCL_QTR_NS + `ALT_SYS_PERIOD_NS - 1) / `ALT_SYS_PERIOD_NS)
`endif

// ### alt_pkg.sv
// Types for the two ends of the limit tracker link, one enum per end
`default_nettype none
package alt_pkg;
  typedef enum logic [2:0] {
    ALT_IDLE = 3'h0,
    ALT_ADDR = 3'h1,
    ALT_ADDR_ACK = 3'h2,
    ALT_WRITE = 3'h3,
    ALT_WR_ACK = 3'h4,
    ALT_READ = 3'h5,
    ALT_RD_ACK = 3'h6
  } alt_tgt_state_t;
  typedef enum logic [2:0] {
    TK_START = 3'h0,
    TK_BYTE = 3'h1,
    TK_RX_ACK = 3'h2,
    TK_RX_NACK = 3'h3,
    TK_STOP = 3'h4,
    TK_DONE = 3'h5
  } alt_tok_t;
endpackage
`default_nettype wire

// ### alt_if.sv
// Two-wire link between controller and target, open-drain resolved here
`default_nettype none
interface alt_if;
  logic scl_oe_c;
  logic scl_do_c;
  logic sda_oe_c;
  logic sda_do_c;
  logic sda_oe_t;
  logic sda_do_t;
  wire logic scl;
  wire logic sda;
  // Pull-up wins unless an enabled driver sends zero; a one is never driven
  assign scl = ~(scl_oe_c & ~scl_do_c);
  assign sda = ~((sda_oe_c & ~sda_do_c) | (sda_oe_t & ~sda_do_t));
  modport target (input scl, input sda, output sda_oe_t, output sda_do_t);
  modport ctrl (input scl, input sda, output scl_oe_c, output scl_do_c,
                output sda_oe_c, output sda_do_c);
endinterface
`default_nettype wire

// ### alt_sync.sv
// Two-flop synchroniser, one chain per bit, idles high like the bus
`default_nettype none
module alt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ### alt_target.sv
// Target end: two-wire register access, limit alerts and min/max tracking
`default_nettype none
`include "alt_defs.svh"
module alt_target import alt_pkg::*; #(
  parameter logic [6:0] TARGET_ADDR = `ALT_TARGET_ADDR
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  alt_if.target link,
  input wire logic [11:0] conv_result_in,
  input wire logic conv_valid_in,
  input wire logic auto_mode_in,
  input wire logic alert_hold_in,
  output logic over_alert_out,
  output logic under_alert_out
);
  logic [1:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  alt_tgt_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] lo_hold_r;
  logic rw_r;
  logic rd_lo_r;
  logic [7:0] ptr_r;
  logic [1:0] widx_r;
  logic [7:0] hi_r;
  logic sda_oe_r;
  logic wr_stb_r;
  logic [15:0] wr_data_r;
  logic [11:0] result_r;
  logic [11:0] upper_threshold_r;
  logic [11:0] lower_threshold_r;
  logic [11:0] hysteresis_amount_r;
  logic [11:0] lowest_conversion_r;
  logic [11:0] highest_conversion_r;
  logic over_r;
  logic under_r;
  logic [15:0] rd_word;
  logic over_set;
  logic under_set;
  logic over_rel;
  logic under_rel;
  logic stat_w1c;

  alt_sync #(.WIDTH(2)) u_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .async_in({link.scl, link.sda}),
    .sync_out(pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // Both lines pass equal sync delay, so their order is kept
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // Reserved upper bits always read zero
  always_comb begin
    unique case (ptr_r)
      `ALT_PTR_RESULT: rd_word = {4'h0, result_r};
      `ALT_PTR_STATUS: rd_word = {14'h0000, over_r, under_r};
      `ALT_PTR_LOWER: rd_word = {4'h0, lower_threshold_r};
      `ALT_PTR_UPPER: rd_word = {4'h0, upper_threshold_r};
      `ALT_PTR_HYST: rd_word = {4'h0, hysteresis_amount_r};
      `ALT_PTR_LOWEST: rd_word = {4'h0, lowest_conversion_r};
      `ALT_PTR_HIGHEST: rd_word = {4'h0, highest_conversion_r};
      default: rd_word = 16'h0000;
    endcase
  end

  // Rate-agnostic: only edges matter, never bit timing
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ALT_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      lo_hold_r <= 8'h00;
      rw_r <= 1'b0;
      rd_lo_r <= 1'b0;
      ptr_r <= 8'h00;
      widx_r <= 2'h0;
      hi_r <= 8'h00;
      sda_oe_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      wr_stb_r <= 1'b0;
      if (stop_det) begin
        state_r <= ALT_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_det) begin
        state_r <= ALT_ADDR;
        cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else begin
        unique case (state_r)
          ALT_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          ALT_ADDR, ALT_WRITE: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (state_r == ALT_ADDR) begin
                if (sh_r[7:1] == TARGET_ADDR) begin
                  state_r <= ALT_ADDR_ACK;
                  sda_oe_r <= 1'b1;
                  rw_r <= sh_r[0];
                end else begin
                  state_r <= ALT_IDLE;
                end
              end else begin
                state_r <= ALT_WR_ACK;
                sda_oe_r <= 1'b1;
                if (widx_r == 2'h0) begin
                  ptr_r <= sh_r;
                  widx_r <= 2'h1;
                end else if (widx_r == 2'h1) begin
                  hi_r <= sh_r;
                  widx_r <= 2'h2;
                end else begin
                  wr_stb_r <= 1'b1;
                  wr_data_r <= {hi_r, sh_r};
                  widx_r <= 2'h1;
                end
              end
            end
          end
          ALT_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                state_r <= ALT_READ;
                tx_r <= rd_word[15:8];
                lo_hold_r <= rd_word[7:0];
                sda_oe_r <= ~rd_word[15];
                rd_lo_r <= 1'b1;
              end else begin
                state_r <= ALT_WRITE;
                sda_oe_r <= 1'b0;
                widx_r <= 2'h0;
              end
            end
          end
          ALT_WR_ACK: begin
            if (scl_fall) begin
              state_r <= ALT_WRITE;
              sda_oe_r <= 1'b0;
            end
          end
          ALT_READ: begin
            if (scl_rise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (cnt_r == 4'h8) begin
                cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
                state_r <= ALT_RD_ACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
              end
            end
          end
          ALT_RD_ACK: begin
            // Not-acknowledge ends the read; wait for stop or restart
            if (scl_rise && sda_s) begin
              state_r <= ALT_IDLE;
            end else if (scl_fall) begin
              state_r <= ALT_READ;
              if (rd_lo_r) begin
                tx_r <= lo_hold_r;
                sda_oe_r <= ~lo_hold_r[7];
              end else begin
                tx_r <= rd_word[15:8];
                lo_hold_r <= rd_word[7:0];
                sda_oe_r <= ~rd_word[15];
              end
              rd_lo_r <= ~rd_lo_r;
            end
          end
          default: begin
            state_r <= ALT_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign link.sda_oe_t = sda_oe_r;
  assign link.sda_do_t = 1'b0;

  // Only bits 11:0 are stored
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      upper_threshold_r <= `ALT_UPPER_RST;
      lower_threshold_r <= `ALT_LOWER_RST;
      hysteresis_amount_r <= `ALT_HYST_RST;
    end else if (wr_stb_r) begin
      if (ptr_r == `ALT_PTR_UPPER) upper_threshold_r <= wr_data_r[11:0];
      if (ptr_r == `ALT_PTR_LOWER) lower_threshold_r <= wr_data_r[11:0];
      if (ptr_r == `ALT_PTR_HYST) hysteresis_amount_r <= wr_data_r[11:0];
    end
  end

  // Host write wins a same-cycle tie so a restart is never lost
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lowest_conversion_r <= `ALT_LOWEST_RST;
      highest_conversion_r <= `ALT_HIGHEST_RST;
      result_r <= 12'h000;
    end else begin
      if (conv_valid_in) result_r <= conv_result_in;
      if (wr_stb_r && ptr_r == `ALT_PTR_LOWEST) begin
        lowest_conversion_r <= wr_data_r[11:0];
      end else if (conv_valid_in && auto_mode_in &&
                   conv_result_in < lowest_conversion_r) begin
        lowest_conversion_r <= conv_result_in;
      end
      if (wr_stb_r && ptr_r == `ALT_PTR_HIGHEST) begin
        highest_conversion_r <= wr_data_r[11:0];
      end else if (conv_valid_in && auto_mode_in &&
                   conv_result_in > highest_conversion_r) begin
        highest_conversion_r <= conv_result_in;
      end
    end
  end

  // Sums widened to 13 bits so result or limit plus hysteresis cannot wrap
  assign over_set = conv_valid_in &&
                    conv_result_in > upper_threshold_r;
  assign under_set = conv_valid_in &&
                     conv_result_in < lower_threshold_r;
  assign over_rel = conv_valid_in && !alert_hold_in &&
    ({1'b0, conv_result_in} + {1'b0, hysteresis_amount_r} <
     {1'b0, upper_threshold_r});
  assign under_rel = conv_valid_in && !alert_hold_in &&
    ({1'b0, conv_result_in} >
     {1'b0, lower_threshold_r} + {1'b0, hysteresis_amount_r});
  assign stat_w1c = wr_stb_r && ptr_r == `ALT_PTR_STATUS;

  // A new violation beats a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      over_r <= 1'b0;
      under_r <= 1'b0;
    end else begin
      if (over_set) over_r <= 1'b1;
      else if (over_rel || (stat_w1c && wr_data_r[`ALT_STAT_OVER]))
        over_r <= 1'b0;
      if (under_set) under_r <= 1'b1;
      else if (under_rel || (stat_w1c && wr_data_r[`ALT_STAT_UNDER]))
        under_r <= 1'b0;
    end
  end

  assign over_alert_out = over_r;
  assign under_alert_out = under_r;
endmodule
`default_nettype wire

// ### alt_ctrl.sv
// Controller end: APB-driven two-wire master for 16-bit register access
`default_nettype none
`include "alt_defs.svh"
module alt_ctrl import alt_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  alt_if.ctrl link
);
  localparam logic [8:0] QTR = 9'(`ALT_SCL_QTR_CYC);
  logic sda_s;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [6:0] tgt_r;
  logic [7:0] ptr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic busy_r;
  logic nack_r;
  logic rd_r;
  logic abort_r;
  logic [3:0] step_r;
  logic [3:0] bit_r;
  logic [1:0] ph_r;
  logic [8:0] qcnt_r;
  logic [7:0] shift_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic apb_acc;
  logic apb_wr;
  logic go;
  logic qtick;
  logic act;
  alt_tok_t tok;
  logic [7:0] bv;
  logic [31:0] rd_mux;
  logic mapped;

  alt_sync #(.WIDTH(1)) u_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .async_in(link.sda),
    .sync_out(sda_s)
  );

  function automatic alt_tok_t tok_of(input logic [3:0] s, input logic rd);
    case (s)
      4'h0: tok_of = TK_START;
      4'h1, 4'h2, 4'h4: tok_of = TK_BYTE;
      4'h3: tok_of = rd ? TK_START : TK_BYTE;
      4'h5: tok_of = rd ? TK_RX_ACK : TK_STOP;
      4'h6: tok_of = rd ? TK_RX_NACK : TK_DONE;
      4'h7: tok_of = rd ? TK_STOP : TK_DONE;
      default: tok_of = TK_DONE;
    endcase
  endfunction

  // Pointer then upper byte then lower byte; address byte carries direction
  always_comb begin
    case (step_r)
      4'h1: bv = {tgt_r, 1'b0};
      4'h2: bv = ptr_r;
      4'h3: bv = wdata_r[15:8];
      4'h4: bv = rd_r ? {tgt_r, 1'b1} : wdata_r[7:0];
      default: bv = 8'h00;
    endcase
  end

  assign tok = tok_of(step_r, rd_r);
  assign apb_acc = psel_in & penable_in;
  assign apb_wr = apb_acc & pready_r & pwrite_in;
  assign go = apb_wr && paddr_in == `ALT_APB_CTRL &&
              pwdata_in[`ALT_CTRL_GO] && !busy_r;
  assign qtick = busy_r && qcnt_r == QTR - 9'h001;
  assign act = busy_r && qcnt_r == 9'h000;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr_in)
      `ALT_APB_TARGET: rd_mux = {25'h0000000, tgt_r};
      `ALT_APB_PTR: rd_mux = {24'h000000, ptr_r};
      `ALT_APB_WDATA: rd_mux = {16'h0000, wdata_r};
      `ALT_APB_CTRL: rd_mux = 32'h00000000;
      `ALT_APB_STATUS: rd_mux = {30'h00000000, nack_r, busy_r};
      `ALT_APB_RDATA: rd_mux = {16'h0000, rdata_r};
      default: begin
        rd_mux = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  // One wait state keeps prdata and pready registered
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      tgt_r <= `ALT_TARGET_ADDR;
      ptr_r <= 8'h00;
      wdata_r <= 16'h0000;
    end else begin
      pready_r <= apb_acc & ~pready_r;
      if (apb_acc & ~pready_r) begin
        prdata_r <= pwrite_in ? 32'h00000000 : rd_mux;
        pslverr_r <= ~mapped;
      end
      if (apb_wr && paddr_in == `ALT_APB_TARGET) tgt_r <= pwdata_in[6:0];
      if (apb_wr && paddr_in == `ALT_APB_PTR) ptr_r <= pwdata_in[7:0];
      if (apb_wr && paddr_in == `ALT_APB_WDATA) wdata_r <= pwdata_in[15:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      rd_r <= 1'b0;
      abort_r <= 1'b0;
      step_r <= 4'h0;
      bit_r <= 4'h0;
      ph_r <= 2'h0;
      qcnt_r <= 9'h000;
    end else if (go) begin
      busy_r <= 1'b1;
      nack_r <= 1'b0;
      abort_r <= 1'b0;
      rd_r <= pwdata_in[`ALT_CTRL_READ];
      step_r <= 4'h0;
      bit_r <= 4'h0;
      ph_r <= 2'h0;
      qcnt_r <= 9'h000;
    end else if (busy_r) begin
      qcnt_r <= qtick ? 9'h000 : qcnt_r + 9'h001;
      if (act && tok == TK_DONE) busy_r <= 1'b0;
      // Target not-acknowledged a sent byte: jump to stop
      if (act && ph_r == 2'h2 && tok == TK_BYTE && bit_r == 4'h8 && sda_s)
      begin
        nack_r <= 1'b1;
        abort_r <= 1'b1;
      end
      if (qtick) begin
        ph_r <= ph_r + 2'h1;
        if (ph_r == 2'h3) begin
          if (tok != TK_START && tok != TK_STOP && bit_r != 4'h8) begin
            bit_r <= bit_r + 4'h1;
          end else begin
            bit_r <= 4'h0;
            abort_r <= 1'b0;
            step_r <= abort_r ? (rd_r ? 4'h7 : 4'h5) : step_r + 4'h1;
          end
        end
      end
    end
  end

  // Line actions at the first cycle of each quarter; low or released only
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      shift_r <= 8'h00;
      rdata_r <= 16'h0000;
    end else if (act) begin
      unique case (tok)
        TK_START: begin
          if (ph_r == 2'h0) sda_oe_r <= 1'b0;
          if (ph_r == 2'h1) scl_oe_r <= 1'b0;
          if (ph_r == 2'h2) sda_oe_r <= 1'b1;
          if (ph_r == 2'h3) scl_oe_r <= 1'b1;
        end
        TK_STOP: begin
          if (ph_r == 2'h0) sda_oe_r <= 1'b1;
          if (ph_r == 2'h1) scl_oe_r <= 1'b0;
          if (ph_r == 2'h2) sda_oe_r <= 1'b0;
        end
        TK_BYTE, TK_RX_ACK, TK_RX_NACK: begin
          if (ph_r == 2'h0) begin
            if (bit_r == 4'h8) sda_oe_r <= (tok == TK_RX_ACK);
            else sda_oe_r <= (tok == TK_BYTE) & ~bv[~bit_r[2:0]];
          end
          if (ph_r == 2'h1) scl_oe_r <= 1'b0;
          if (ph_r == 2'h2 && bit_r != 4'h8) shift_r <= {shift_r[6:0], sda_s};
          if (ph_r == 2'h3) begin
            scl_oe_r <= 1'b1;
            if (bit_r == 4'h8 && tok == TK_RX_ACK) rdata_r[15:8] <= shift_r;
            if (bit_r == 4'h8 && tok == TK_RX_NACK) rdata_r[7:0] <= shift_r;
          end
        end
        TK_DONE: begin
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
        end
        default: begin
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.scl_oe_c = scl_oe_r;
  assign link.sda_oe_c = sda_oe_r;
  assign link.scl_do_c = 1'b0;
  assign link.sda_do_c = 1'b0;
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
endmodule
`default_nettype wire

// ### alt_properties.sv
// Concurrent checks on the two-wire link between both ends
`default_nettype none
module alt_properties (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic scl_oe_c,
  input wire logic sda_oe_c,
  input wire logic sda_oe_t,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);
  // Start and stop are the only data moves while the clock is high
  sequence s_start;
    $rose(sda_oe_c) && scl;
  endsequence
  sequence s_stop;
    $fell(sda_oe_c) && scl;
  endsequence
  // Controller data moves a whole quarter away from its clock moves
  property p_data_setup;
    $changed(sda_oe_c) |-> $stable(scl_oe_c)[*8];
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("controller moved data and clock together");
  property p_scl_high;
    $fell(scl_oe_c) |-> (!scl_oe_c)[*8];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  property p_start;
    s_start |-> (scl && !sda_oe_t)[*8];
  endproperty
  a_start: assert property (p_start)
    else $error("clock not held high after start");
  property p_stop;
    s_stop |=> (sda && scl)[*8];
  endproperty
  a_stop: assert property (p_stop)
    else $error("link not idle after stop");
  property p_data_stable;
    $rose(scl) |=> $stable(sda)[*8];
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("data moved right after clock rise");
  property p_tgt_edge;
    $changed(sda_oe_t) |-> !scl;
  endproperty
  a_tgt_edge: assert property (p_tgt_edge)
    else $error("target moved data while clock high");
  // Overlap is harmless on open drain, but the controller must let go
  property p_ack_free;
    $rose(sda_oe_t) |-> ##[0:100] !sda_oe_c;
  endproperty
  a_ack_free: assert property (p_ack_free)
    else $error("controller kept data line during target slot");
  property p_tgt_hold;
    $rose(sda_oe_t) |-> (sda_oe_t && !scl)[*8];
  endproperty
  a_tgt_hold: assert property (p_tgt_hold)
    else $error("target pull-down too short");
endmodule
`default_nettype wire

// ### adc_limit_tracking_i2c_regs_test.sv
// Bench: APB drives the controller, which talks to the limit target
`default_nettype none
module adc_limit_tracking_i2c_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] res = 12'h000;
  logic valid = 1'h0;
  logic auto = 1'h0;
  logic hold = 1'h0;
  logic over;
  logic under;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int checked = 0;
  always #4 clk = ~clk;
  alt_if i_alt_if ();
  alt_ctrl i_alt_ctrl (.sys_clk_in(clk), .nrst_in(nrst), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .link(i_alt_if));
  alt_target i_alt_target (.sys_clk_in(clk), .nrst_in(nrst),
    .link(i_alt_if), .conv_result_in(res), .conv_valid_in(valid),
    .auto_mode_in(auto), .alert_hold_in(hold), .over_alert_out(over),
    .under_alert_out(under));
  alt_properties i_alt_properties (.sys_clk_in(clk), .nrst_in(nrst),
    .scl_oe_c(i_alt_if.scl_oe_c), .sda_oe_c(i_alt_if.sda_oe_c),
    .sda_oe_t(i_alt_if.sda_oe_t), .scl(i_alt_if.scl), .sda(i_alt_if.sda));
  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  // Frames take thousands of cycles; the watchdog bounds a hung poll
  task automatic frame(input logic [7:0] ptr, input logic [15:0] wd,
      input logic rdir);
    apb(1'h1, 8'h04, {24'h0, ptr});
    apb(1'h1, 8'h08, {16'h0, wd});
    apb(1'h1, 8'h0C, {30'h0, rdir, 1'h1});
    do begin
      apb(1'h0, 8'h10, 32'h0);
    end while (rd[0] !== 1'h0);
  endtask
  // Flags land on the edge that samples the pulse
  task automatic conv(input logic [11:0] r, input logic a,
      input logic [1:0] exp);
    res <= r;
    valid <= 1'h1;
    auto <= a;
    @(posedge clk);
    valid <= 1'h0;
    @(posedge clk);
    chk({30'h0, under, over}, {30'h0, exp});
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    repeat (4) @(posedge clk);
    chk({30'h0, under, over}, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h54);
    apb(1'h0, 8'h18, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'h1, 8'h00, 32'h55);
    frame(8'h04, 16'h0FFF, 1'h0);
    chk(rd, 32'h2);
    apb(1'h1, 8'h00, 32'h54);
    frame(8'h04, 16'h0800, 1'h0);
    chk(rd, 32'h0);
    frame(8'h05, 16'h0010, 1'h0);
    chk(rd, 32'h0);
    frame(8'h03, 16'h0100, 1'h0);
    chk(rd, 32'h0);
    conv(12'h801, 1'h0, 2'h1);
    conv(12'h7F0, 1'h0, 2'h1);
    conv(12'h7EF, 1'h0, 2'h0);
    conv(12'h0FF, 1'h0, 2'h2);
    conv(12'h110, 1'h0, 2'h2);
    conv(12'h111, 1'h0, 2'h0);
    hold <= 1'h1;
    conv(12'hFFF, 1'h0, 2'h1);
    conv(12'h000, 1'h0, 2'h3);
    conv(12'h300, 1'h1, 2'h3);
    conv(12'h200, 1'h1, 2'h3);
    conv(12'h280, 1'h1, 2'h3);
    conv(12'h350, 1'h1, 2'h3);
    frame(8'h06, 16'h0000, 1'h1);
    chk(rd, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk(rd, 32'h200);
    frame(8'h07, 16'h0000, 1'h1);
    chk(rd, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk(rd, 32'h350);
    stop_test();
  end
endmodule
`default_nettype wire
